//--- tcc_consts.svh
// Constants of the 16-bit capture/compare timer: register indices, field positions, reset values.
// Assumes a Wishbone slave with 32-bit data; byte address is four times the register index.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register indices (byte address = index * 4)
`define TCC_IDX_COUNT 16'hFF10
`define TCC_IDX_CAPA 16'hFF12
`define TCC_IDX_CAPB 16'hFF14
`define TCC_IDX_MODE 16'hFF20
`define TCC_IDX_CCTL 16'hFF21
`define TCC_IDX_EDGE 16'hFF22
`define TCC_IDX_TRIG 16'hFF23

// Field positions in the mode register
`define TCC_MODE_OVF_BIT 0
`define TCC_MODE_RUN_LO 2
`define TCC_MODE_RUN_HI 3
`define TCC_MODE_OS_BIT 4

// Field positions in the capture/compare control register
`define TCC_CCTL_MODE_A_BIT 0
`define TCC_CCTL_TRIG_A_BIT 1
`define TCC_CCTL_MODE_B_BIT 2

// Field positions in the edge select register
`define TCC_EDGE_IN0_LO 4
`define TCC_EDGE_IN0_HI 5
`define TCC_EDGE_IN1_LO 6
`define TCC_EDGE_IN1_HI 7

// One-shot trigger strobe bit
`define TCC_TRIG_OS_BIT 0

// Reset values and limits
`define TCC_CNT_RESET 16'h0000
`define TCC_CAP_RESET 16'h0000
`define TCC_CNT_MAX 16'hFFFF

`endif

//--- tcc_pin_model.sv
// Model of what stands beyond the timer: the two input pins and the interrupt receiver.
// Assumes the bench requests pin levels; pins move only just after a rising CLK edge.
`timescale 1ns/1ps

module tcc_pin_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requested pin levels
  input wire logic want_in0,
  input wire logic want_in1,
  // Interrupt requests from the timer
  input wire logic irq_a,
  input wire logic irq_b,
  // Pins toward the timer
  output logic timer_in0,
  output logic timer_in1,
  // Interrupt pulse counts
  output int irq_a_cnt,
  output int irq_b_cnt
);
  // Pins are registered so an edge is never coincident with the sampling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_in0 <= 1'b0;
      timer_in1 <= 1'b0;
      irq_a_cnt <= 0;
      irq_b_cnt <= 0;
    end else begin
      timer_in0 <= want_in0;
      timer_in1 <= want_in1;
      irq_a_cnt <= irq_a_cnt + (irq_a === 1'b1);
      irq_b_cnt <= irq_b_cnt + (irq_b === 1'b1);
    end
  end
endmodule

//--- tcc_pkg.sv
// Types of the 16-bit capture/compare timer: bus carriers, mode encodings, the state record.
// Assumes tcc_consts.svh for all numeric constants.
package tcc_pkg;

  // Run mode encoding
  typedef enum logic [1:0] {
    TCC_RUN_STOP = 2'h0,
    TCC_RUN_FREE = 2'h1,
    TCC_RUN_EDGE = 2'h2,
    TCC_RUN_MATCH = 2'h3
  } tcc_run_e;

  // Edge select encoding; the third code selects no edge
  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_NONE = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_e;

  // Wishbone classic request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [17:0] adr;
    logic [31:0] dat;
  } tcc_wb_req_s;

  // Wishbone classic answer from this slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tcc_wb_rsp_s;

  // Whole state of the timer
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cap_a;
    logic [15:0] cap_b;
    tcc_run_e run_mode;
    logic ovf;
    logic oneshot_en;
    logic trig_sel_a;
    logic mode_a;
    logic mode_b;
    tcc_edge_e edge_in0;
    tcc_edge_e edge_in1;
    logic in0_q;
    logic in1_q;
    logic first;
    logic ack;
    logic [31:0] dat;
    logic irq_a;
    logic irq_b;
  } tcc_state_s;

  // Edge detector for one input under an edge select code
  function automatic logic tcc_edge_hit(tcc_edge_e sel, logic prev, logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (sel)
      TCC_EDGE_RISE: tcc_edge_hit = rise;
      TCC_EDGE_FALL: tcc_edge_hit = fall;
      TCC_EDGE_BOTH: tcc_edge_hit = rise | fall;
      default: tcc_edge_hit = 1'b0;
    endcase
  endfunction

endpackage

//--- tcc_timer.sv
// 16-bit up-counter with two capture/compare registers behind a Wishbone classic slave.
// Assumes timer inputs synchronous to CLK; the count clock is CLK itself.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tcc_timer (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Wishbone classic slave
  input wire tcc_pkg::tcc_wb_req_s WB_REQ,
  output tcc_pkg::tcc_wb_rsp_s WB_RSP,
  // Timer input pins
  input wire logic TIMER_IN0,
  input wire logic TIMER_IN1,
  // Interrupt requests, one-cycle pulses
  output logic MATCH_IRQ_A,
  output logic MATCH_IRQ_B
);
  import tcc_pkg::*;

  tcc_state_s s;
  tcc_state_s next_s;

  logic req;
  logic rd;
  logic wr;
  logic [15:0] idx;
  logic cnt_read;
  logic running;
  logic tick;
  logic v0;
  logic v1;
  logic rev0;
  logic match_a;
  logic match_b;
  logic clr_edge;
  logic clr_match;
  logic clr_os;
  logic os_wr;
  logic [31:0] rd_data;

  // Bus decode; a new request is taken only while no answer stands
  assign req = WB_REQ.cyc & WB_REQ.stb & ~s.ack;
  assign rd = req & ~WB_REQ.we;
  assign wr = req & WB_REQ.we;
  assign idx = WB_REQ.adr[17:2];
  assign cnt_read = rd && (idx == `TCC_IDX_COUNT);
  assign running = (s.run_mode != TCC_RUN_STOP);

  // count hold-off
  // The read cycle swallows one count so the value returned cannot tear.
  assign tick = running & ~cnt_read;

  assign v0 = tcc_edge_hit(s.edge_in0, s.in0_q, TIMER_IN0);
  assign v1 = tcc_edge_hit(s.edge_in1, s.in1_q, TIMER_IN1);
  // reversed phase
  // Both-edge select has no opposite edge, so it never triggers here.
  always_comb begin
    case (s.edge_in0)
      TCC_EDGE_RISE: rev0 = tcc_edge_hit(TCC_EDGE_FALL, s.in0_q, TIMER_IN0);
      TCC_EDGE_FALL: rev0 = tcc_edge_hit(TCC_EDGE_RISE, s.in0_q, TIMER_IN0);
      default: rev0 = 1'b0;
    endcase
  end

  // zero compare
  // The first tick after start is not compared, so zero only matches after a clear or a wrap.
  assign match_a = tick & ~s.first & ~s.mode_a & (s.cnt == s.cap_a);
  assign match_b = tick & ~s.first & ~s.mode_b & (s.cnt == s.cap_b);

  assign clr_edge = running & (s.run_mode == TCC_RUN_EDGE) & v0;
  assign clr_match = (s.run_mode == TCC_RUN_MATCH) & match_a;
  assign os_wr = wr && (idx == `TCC_IDX_TRIG) && WB_REQ.sel[0] && WB_REQ.dat[`TCC_TRIG_OS_BIT];
  assign clr_os = running & s.oneshot_en & (os_wr | v0);

  // Read multiplexer
  always_comb begin
    rd_data = 32'h00000000;
    case (idx)
      `TCC_IDX_COUNT: rd_data[15:0] = running ? s.cnt : `TCC_CNT_RESET;
      `TCC_IDX_CAPA: rd_data[15:0] = s.cap_a;
      `TCC_IDX_CAPB: rd_data[15:0] = s.cap_b;
      `TCC_IDX_MODE: begin
        rd_data[`TCC_MODE_RUN_HI:`TCC_MODE_RUN_LO] = s.run_mode;
        rd_data[`TCC_MODE_OVF_BIT] = s.ovf;
        rd_data[`TCC_MODE_OS_BIT] = s.oneshot_en;
      end
      `TCC_IDX_CCTL: begin
        rd_data[`TCC_CCTL_MODE_A_BIT] = s.mode_a;
        rd_data[`TCC_CCTL_TRIG_A_BIT] = s.trig_sel_a;
        rd_data[`TCC_CCTL_MODE_B_BIT] = s.mode_b;
      end
      `TCC_IDX_EDGE: begin
        rd_data[`TCC_EDGE_IN0_HI:`TCC_EDGE_IN0_LO] = s.edge_in0;
        rd_data[`TCC_EDGE_IN1_HI:`TCC_EDGE_IN1_LO] = s.edge_in1;
      end
      default: rd_data = 32'h00000000;
    endcase
  end

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.ack = req;
    next_s.irq_a = 1'b0;
    next_s.irq_b = 1'b0;
    next_s.in0_q = TIMER_IN0;
    next_s.in1_q = TIMER_IN1;
    if (rd) begin
      next_s.dat = rd_data;
    end

    // Register writes; the counter has no write path
    if (wr) begin
      case (idx)
        `TCC_IDX_CAPA: begin
          if (WB_REQ.sel[1:0] == 2'h3) begin
            next_s.cap_a = WB_REQ.dat[15:0];
          end
        end
        `TCC_IDX_CAPB: begin
          if (WB_REQ.sel[1:0] == 2'h3) begin
            next_s.cap_b = WB_REQ.dat[15:0];
          end
        end
        `TCC_IDX_MODE: begin
          if (WB_REQ.sel[0]) begin
            next_s.run_mode = tcc_run_e'(WB_REQ.dat[`TCC_MODE_RUN_HI:`TCC_MODE_RUN_LO]);
            next_s.oneshot_en = WB_REQ.dat[`TCC_MODE_OS_BIT];
            if (!WB_REQ.dat[`TCC_MODE_OVF_BIT]) begin
              next_s.ovf = 1'b0;
            end
          end
        end
        `TCC_IDX_CCTL: begin
          if (WB_REQ.sel[0]) begin
            next_s.mode_a = WB_REQ.dat[`TCC_CCTL_MODE_A_BIT];
            next_s.trig_sel_a = WB_REQ.dat[`TCC_CCTL_TRIG_A_BIT];
            next_s.mode_b = WB_REQ.dat[`TCC_CCTL_MODE_B_BIT];
          end
        end
        `TCC_IDX_EDGE: begin
          if (WB_REQ.sel[0]) begin
            next_s.edge_in0 = tcc_edge_e'(WB_REQ.dat[`TCC_EDGE_IN0_HI:`TCC_EDGE_IN0_LO]);
            next_s.edge_in1 = tcc_edge_e'(WB_REQ.dat[`TCC_EDGE_IN1_HI:`TCC_EDGE_IN1_LO]);
          end
        end
        default: begin
        end
      endcase
    end

    if (next_s.run_mode == TCC_RUN_STOP) begin
      next_s.cnt = `TCC_CNT_RESET;
      next_s.ovf = 1'b0;
    end else if (clr_edge || clr_match || clr_os) begin
      next_s.cnt = `TCC_CNT_RESET;
    end else if (tick) begin
      next_s.cnt = 16'(s.cnt + 16'h0001);
      // Overflow set wins over a clear written in the same cycle
      if (s.cnt == `TCC_CNT_MAX) begin
        next_s.ovf = 1'b1;
      end
    end

    if (next_s.run_mode == TCC_RUN_STOP) begin
      next_s.first = 1'b1;
    end else if (tick) begin
      next_s.first = 1'b0;
    end

    if (match_a) begin
      next_s.irq_a = 1'b1;
    end
    if (match_b) begin
      next_s.irq_b = 1'b1;
    end

    // compare ignores captures
    // A capture beats a software write in the same cycle: the sampled count is kept.
    // capture a trigger
    if (s.mode_a) begin
      if (s.trig_sel_a) begin
        if (rev0) begin
          next_s.cap_a = s.cnt;
        end
        if (v1) begin
          next_s.irq_a = 1'b1;
        end
      end else if (v1) begin
        next_s.cap_a = s.cnt;
        next_s.irq_a = 1'b1;
      end
    end
    // only pin edges capture, never a counter read
    if (s.mode_b && v0) begin
      next_s.cap_b = s.cnt;
      next_s.irq_b = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '0;
      s.cnt <= `TCC_CNT_RESET;
      s.cap_a <= `TCC_CAP_RESET;
      s.cap_b <= `TCC_CAP_RESET;
      s.run_mode <= TCC_RUN_STOP;
      s.edge_in0 <= TCC_EDGE_FALL;
      s.edge_in1 <= TCC_EDGE_FALL;
      s.first <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign WB_RSP.ack = s.ack;
  assign WB_RSP.dat = s.dat;
  assign MATCH_IRQ_A = s.irq_a;
  assign MATCH_IRQ_B = s.irq_b;

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  cnt_step_a: assert property (tick && !clr_edge && !clr_match && !clr_os && !wr |=>
    s.cnt == 16'($past(s.cnt) + 16'h0001))
    else $error("counter did not step by one");

  rd_freeze_a: assert property (cnt_read && running && !wr && !clr_edge && !clr_os |=>
    s.ack && s.dat[15:0] == $past(s.cnt) && s.cnt == $past(s.cnt))
    else $error("counter read not frozen");

  rd_stop_zero_a: assert property (cnt_read && !running |=> s.dat == 32'h00000000)
    else $error("stopped counter read not zero");

  stop_clear_a: assert property (s.run_mode == TCC_RUN_STOP |-> s.cnt == 16'h0000)
    else $error("stopped counter not zero");

  edge_clear_a: assert property (clr_edge |=> s.cnt == 16'h0000 ##1
    (s.run_mode == TCC_RUN_STOP || s.cnt <= 16'h0001))
    else $error("edge clear failed");

  match_clear_a: assert property (clr_match && s.run_mode == $past(s.run_mode) |=> s.cnt == 16'h0000)
    else $error("match clear failed");

  os_clear_a: assert property (clr_os && !(wr && idx == `TCC_IDX_MODE) |=> s.cnt == 16'h0000)
    else $error("one-shot clear failed");

  cmp_hold_a: assert property (!s.mode_a && !(wr && idx == `TCC_IDX_CAPA) |=> $stable(s.cap_a))
    else $error("compare value changed");

  irq_a_match_a: assert property (match_a |=> MATCH_IRQ_A ##1 !MATCH_IRQ_A || $past(match_a) || $past(v1))
    else $error("match a interrupt missing");

  irq_b_match_a: assert property (match_b |=> MATCH_IRQ_B)
    else $error("match b interrupt missing");

  cmp_b_hold_a: assert property (!s.mode_b && !(wr && idx == `TCC_IDX_CAPB) |=> $stable(s.cap_b))
    else $error("compare b value changed");

  rd_no_cap_a: assert property (cnt_read && !v0 |=> $stable(s.cap_b))
    else $error("counter read captured into b");

  part_write_a: assert property (wr && idx == `TCC_IDX_CAPA && WB_REQ.sel[1:0] != 2'h3 && !s.mode_a |=>
    $stable(s.cap_a))
    else $error("partial write changed register a");

  cap_in1_a: assert property (s.mode_a && !s.trig_sel_a && v1 |=>
    s.cap_a == $past(s.cnt) && MATCH_IRQ_A)
    else $error("timer_in1 capture failed");

  both_no_rev_a: assert property (s.edge_in0 == TCC_EDGE_BOTH |-> !rev0)
    else $error("reversed edge under both-edge select");

  in1_ext_irq_a: assert property (s.mode_a && s.trig_sel_a && v1 && !rev0 && !(wr && idx == `TCC_IDX_CAPA) |=>
    $stable(s.cap_a) && MATCH_IRQ_A)
    else $error("external interrupt path wrong");

  cap_b_a: assert property (s.mode_b && v0 |=> s.cap_b == $past(s.cnt) && MATCH_IRQ_B)
    else $error("capture b failed");

  rev_quiet_a: assert property (s.mode_a && s.trig_sel_a && rev0 && !v1 && !match_a |=>
    s.cap_a == $past(s.cnt) && !MATCH_IRQ_A)
    else $error("reversed capture raised interrupt");

  zero_start_a: assert property (s.first && tick |=> !MATCH_IRQ_A || $past(v1))
    else $error("match right after start");

  cov_cnt_read: cover property (cnt_read && running);
  cov_cap_b: cover property (s.mode_b && v0);
  cov_match_clear: cover property (clr_match);
  cov_edge_clear: cover property (clr_edge);
  cov_ovf: cover property (tick && s.cnt == 16'hFFFF);

endmodule

//--- testbench.sv
// Self-checking bench for the capture/compare timer: register table loop, then hand tests.
// Assumes the timer acks each Wishbone request one cycle after taking it.
`timescale 1ns/1ps
`include "tcc_consts.svh"

module testbench;
  import tcc_pkg::*;
  typedef struct {logic we; logic [15:0] idx; logic [31:0] wd; logic [31:0] exp;} tcc_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tcc_wb_req_s req = '0;
  tcc_wb_rsp_s rsp;
  logic in0;
  logic in1;
  logic irq_a;
  logic irq_b;
  logic want0 = 1'b0;
  logic want1 = 1'b0;
  int irq_a_cnt;
  int irq_b_cnt;
  int failures = 0;
  int comparisons = 0;
  int a0;
  int b0;
  logic [31:0] v1;
  logic [31:0] v2;
  tcc_row_s rows[5] = '{
    '{1'b1, `TCC_IDX_CAPA, 32'h0000A55A, 32'h0}, '{1'b0, `TCC_IDX_CAPA, 32'h0, 32'h0000A55A},
    '{1'b1, `TCC_IDX_CAPB, 32'hFFFF1234, 32'h0}, '{1'b0, `TCC_IDX_CAPB, 32'h0, 32'h00001234},
    '{1'b0, 16'h0010, 32'h0, 32'h0}};

  always #5 clk = ~clk;

  tcc_timer u_tcc_timer (.CLK(clk), .RESET_N(rst_n), .WB_REQ(req), .WB_RSP(rsp), .TIMER_IN0(in0),
    .TIMER_IN1(in1), .MATCH_IRQ_A(irq_a), .MATCH_IRQ_B(irq_b));
  tcc_pin_model u_tcc_pin_model (.clk(clk), .rst_n(rst_n), .want_in0(want0), .want_in1(want1),
    .irq_a(irq_a), .irq_b(irq_b), .timer_in0(in0), .timer_in1(in1), .irq_a_cnt(irq_a_cnt),
    .irq_b_cnt(irq_b_cnt));

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; waits for ack without assuming its latency
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: {idx, 2'b00}, dat: d};
    do begin
      @(negedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    // Ack is seen settled mid-cycle; the request is released at the rising edge that samples it
    @(posedge clk);
    q = rsp.dat;
    req <= '0;
    if (n >= 50) failures++;
  endtask

  task automatic run(input logic [31:0] m);
    wb(1'b1, `TCC_IDX_MODE, m, v2);
  endtask

  initial begin
    #500000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].idx, rows[i].wd, v1);
      if (!rows[i].we) chk(v1, rows[i].exp);
    end
    wb(1'b1, `TCC_IDX_COUNT, 32'hFFFF, v1);
    wb(1'b0, `TCC_IDX_COUNT, 0, v1);
    chk(v1, 0);
    run(32'h4);
    wb(1'b0, `TCC_IDX_COUNT, 0, v1);
    wb(1'b0, `TCC_IDX_COUNT, 0, v2);
    chk(v1 !== 0, 1);
    chk(v2, v1 + 32'h2);
    run(32'h0);
    wb(1'b0, `TCC_IDX_COUNT, 0, v1);
    chk(v1, 0);
    // control and capcmp_a writes only while stopped
    wb(1'b1, `TCC_IDX_CCTL, 32'h5, v1);
    wb(1'b1, `TCC_IDX_EDGE, 32'h50, v1);
    run(32'h4);
    b0 = irq_b_cnt;
    want0 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(irq_b_cnt, b0 + 1);
    a0 = irq_a_cnt;
    want1 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(irq_a_cnt, a0 + 1);
    wb(1'b0, `TCC_IDX_CAPA, 0, v1);
    chk(v1 !== 0, 1);
    wb(1'b0, `TCC_IDX_CAPB, 0, v1);
    wb(1'b0, `TCC_IDX_COUNT, 0, v2);
    wb(1'b0, `TCC_IDX_CAPB, 0, v2);
    chk(v2, v1);
    run(32'h0);
    wb(1'b1, `TCC_IDX_CCTL, 32'h3, v1);
    run(32'h4);
    wb(1'b0, `TCC_IDX_CAPA, 0, v1);
    a0 = irq_a_cnt;
    want0 <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, `TCC_IDX_CAPA, 0, v2);
    chk(v2 !== v1, 1);
    chk(irq_a_cnt, a0);
    want1 <= 1'b0;
    repeat (2) @(posedge clk);
    want1 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(irq_a_cnt, a0 + 1);
    wb(1'b0, `TCC_IDX_CAPA, 0, v1);
    chk(v1, v2);
    run(32'h0);
    wb(1'b1, `TCC_IDX_EDGE, 32'h30, v1);
    run(32'h4);
    wb(1'b0, `TCC_IDX_CAPA, 0, v1);
    want0 <= 1'b1;
    repeat (3) @(posedge clk);
    want0 <= 1'b0;
    repeat (3) @(posedge clk);
    wb(1'b0, `TCC_IDX_CAPA, 0, v2);
    chk(v2, v1);
    run(32'h0);
    // interval use keeps capcmp_a above zero
    wb(1'b1, `TCC_IDX_CAPA, 32'h5, v1);
    wb(1'b1, `TCC_IDX_CCTL, 32'h0, v1);
    run(32'hC);
    a0 = irq_a_cnt;
    repeat (40) @(posedge clk);
    chk(irq_a_cnt - a0 >= 5, 1);
    wb(1'b0, `TCC_IDX_COUNT, 0, v1);
    chk(v1 <= 5, 1);
    want1 <= 1'b0;
    repeat (3) @(posedge clk);
    wb(1'b0, `TCC_IDX_CAPA, 0, v1);
    chk(v1, 32'h5);
    run(32'h0);
    wb(1'b1, `TCC_IDX_CAPB, 32'h3, v1);
    run(32'h4);
    b0 = irq_b_cnt;
    repeat (20) @(posedge clk);
    chk(irq_b_cnt, b0 + 1);
    // Edge clear of a running count: a late timer_in0 rise restarts the count
    run(32'h0);
    wb(1'b1, `TCC_IDX_EDGE, 32'h50, v1);
    run(32'h8);
    repeat (20) @(posedge clk);
    want0 <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, `TCC_IDX_COUNT, 0, v1);
    chk(v1 !== 0 && v1 < 8, 1);
    run(32'h0);
    run(32'h14);
    repeat (30) @(posedge clk);
    wb(1'b1, `TCC_IDX_TRIG, 32'h1, v1);
    wb(1'b0, `TCC_IDX_COUNT, 0, v1);
    chk(v1 !== 0 && v1 < 8, 1);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, `TCC_IDX_CAPA, 0, v1);
    chk(v1, 0);
    wb(1'b0, `TCC_IDX_COUNT, 0, v1);
    chk(v1, 0);
    end_sim();
  end
endmodule
